// File: hdl/arcc_top.v
// Converter control: serial access, timing source, rate tables, result FIFO.
// Assumes all inputs are synchronous to i_clock; the analog side supplies
// a finished result word on i_sample_data when a conversion ends.
`timescale 1ns/10ps
`include "arcc_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Result FIFO
module arcc_fifo #(
   parameter P_WIDTH = 16,
   parameter P_DEPTH = 8,
   parameter P_AW    = 3
) (
   // Clock and reset
   input  wire               i_clock,
   input  wire               i_arst_n,
   // Fill side
   input  wire               i_in_valid,
   input  wire [P_WIDTH-1:0] i_in_data,
   output wire               o_in_ready,
   // Drain side
   output wire               o_out_valid,
   output wire [P_WIDTH-1:0] o_out_data,
   input  wire               i_out_ready
);
   reg [P_WIDTH-1:0] mem [0:P_DEPTH-1]; // Storage, no reset needed
   reg [P_AW-1:0]    wr_q;              // Write pointer
   reg [P_AW-1:0]    rd_q;              // Read pointer
   reg [P_AW:0]      cnt_q;             // Words held
   wire              push;
   wire              pop;

   assign o_in_ready  = (cnt_q != P_DEPTH[P_AW:0]);
   assign o_out_valid = (cnt_q != {(P_AW+1){1'b0}});
   assign o_out_data  = mem[rd_q];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = i_out_ready & o_out_valid;

   // Storage write
   always @(posedge i_clock) begin
      if (push) begin
         mem[wr_q] <= i_in_data;
      end
   end

   // Pointers wrap at the depth so it need not be a power of two
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_q  <= {P_AW{1'b0}};
         rd_q  <= {P_AW{1'b0}};
         cnt_q <= {(P_AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == P_DEPTH[P_AW-1:0] - 1'b1) ? {P_AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == P_DEPTH[P_AW-1:0] - 1'b1) ? {P_AW{1'b0}} : rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // arcc_fifo

////////////////////////////////////////////////////////////////////////////////
// Top level
module arcc_top #(
   parameter P_LEN_SHIFT = 0, // Shortens conversions for simulation
   parameter P_FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire        i_clock,
   input  wire        i_arst_n,
   // Serial port
   input  wire        i_cs_n,
   input  wire        i_sclk,
   input  wire        i_din,
   output reg         o_rdy_dout,
   output reg         o_rdy_dout_oe_n,
   // Timing source
   input  wire        i_ext_clk,
   // Analog side
   input  wire [15:0] i_sample_data,
   output reg         o_mod_sample,
   output reg         o_conv_end,
   output reg         o_input_buffer_enable,
   output reg         o_unipolar,
   output reg         o_external_timing_source_sel,
   output reg         o_mains_frequency_select,
   output reg  [2:0]  o_rate_code,
   // Auxiliary pins
   input  wire [3:0]  i_aux_pin,
   output reg  [3:0]  o_aux_pin,
   output reg  [3:0]  o_aux_pin_oe_n
);
   localparam [63:0] L_FAST = (64'd`ARCC_OSC_FAST_HZ << `ARCC_NCO_BITS) / 64'd`ARCC_CLK_HZ;
   localparam [63:0] L_SLOW = (64'd`ARCC_OSC_SLOW_HZ << `ARCC_NCO_BITS) / 64'd`ARCC_CLK_HZ;
   localparam [`ARCC_NCO_BITS-1:0] L_INC_FAST = L_FAST[`ARCC_NCO_BITS-1:0];
   localparam [`ARCC_NCO_BITS-1:0] L_INC_SLOW = L_SLOW[`ARCC_NCO_BITS-1:0];
   localparam [1:0] S_IDLE = 2'h0; // No conversion
   localparam [1:0] S_RUN  = 2'h1; // Counting samples
   localparam [1:0] S_HOLD = 2'h2; // Result waiting for FIFO room

   // Samples per result from mode and rate code
   function [17:0] conv_len;
      input       single;
      input [2:0] code;
      begin
         if (single) begin
            case (code)
               3'h0:    conv_len = `ARCC_LEN_SNG_0;
               3'h1:    conv_len = `ARCC_LEN_SNG_1;
               3'h2:    conv_len = `ARCC_LEN_SNG_2;
               3'h3:    conv_len = `ARCC_LEN_SNG_3;
               3'h4:    conv_len = `ARCC_LEN_SNG_4;
               3'h5:    conv_len = `ARCC_LEN_SNG_5;
               3'h6:    conv_len = `ARCC_LEN_SNG_6;
               default: conv_len = `ARCC_LEN_SNG_7;
            endcase
         end else begin
            case (code)
               3'h5:    conv_len = `ARCC_LEN_CONT_5;
               3'h6:    conv_len = `ARCC_LEN_CONT_6;
               3'h7:    conv_len = `ARCC_LEN_CONT_7;
               default: conv_len = `ARCC_LEN_CONT_4;
            endcase
         end
      end
   endfunction

   reg  [7:0]  ctrl_q;     // First control register
   reg  [3:0]  aux_dir_q;  // 1 = pin driven
   reg  [3:0]  aux_lvl_q;  // Driven level
   reg         sclk_q;     // Previous serial clock
   reg         cs_n_q;     // Previous chip select
   reg         external_timing_source_sel_q;   // Previous external clock
   reg  [4:0]  bit_q;      // Input bits this frame
   reg  [6:0]  sin_q;      // Input shifter
   reg  [7:0]  cmd_q;      // Latched command byte
   reg  [15:0] sout_q;     // Output shifter
   reg  [4:0]  obit_q;     // Output bits left
   reg  [`ARCC_NCO_BITS-1:0] nco_q; // Oscillator phase
   reg  [3:0]  div_q;      // Timing tick to sample divider
   reg  [1:0]  st_q;       // Conversion state
   reg  [17:0] cnt_q;      // Samples into conversion
   reg  [1:0]  settle_q;   // Results discarded so far
   reg         start_q;    // Conversion command pulse
   wire        rise;
   wire        fall;
   wire [7:0]  byte_in;
   wire [`ARCC_NCO_BITS:0] nco_sum;
   wire        sys_tick;
   wire        fs_tick;
   wire [17:0] len;
   wire        f_rdy;
   wire        f_vld;
   wire [15:0] f_data;
   wire        f_push;
   wire        f_pop;

   // Serial clock edges only count inside a frame
   assign rise    = i_sclk & ~sclk_q & ~i_cs_n;
   assign fall    = ~i_sclk & sclk_q & ~i_cs_n;
   assign byte_in = {sin_q, i_din};
   assign f_pop   = rise & (bit_q == `ARCC_CMD_BITS) & byte_in[`ARCC_CMD_REG_BIT]
                    & byte_in[`ARCC_CMD_RD_BIT] & (byte_in[1:0] == `ARCC_ADDR_DATA);

   ////////////////////////////////////////////////////////////////////////////
   // Serial input and register writes
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sclk_q    <= 1'b0;
         cs_n_q    <= 1'b1;
         bit_q     <= 5'h00;
         sin_q     <= 7'h00;
         cmd_q     <= 8'h00;
         ctrl_q    <= `ARCC_CTL_RESET;
         aux_dir_q <= 4'h0;
         aux_lvl_q <= 4'h0;
         start_q   <= 1'b0;
         o_rate_code <= 3'h0; // Rate code of the last conversion command
      end else begin
         sclk_q  <= i_sclk;
         cs_n_q  <= i_cs_n;
         start_q <= 1'b0;
         if (i_cs_n) begin
            bit_q <= 5'h00; // Frame ends, partial bytes dropped
         end else if (rise) begin
            sin_q <= byte_in[6:0];
            if (bit_q != `ARCC_OUT_BITS) begin
               bit_q <= bit_q + 1'b1;
            end
            if (bit_q == `ARCC_CMD_BITS) begin
               cmd_q <= byte_in;
               // Conversion command carries the rate code
               if (!byte_in[`ARCC_CMD_REG_BIT]) begin
                  o_rate_code <= byte_in[2:0];
                  start_q     <= 1'b1;
               end
            end else if (bit_q == `ARCC_WR_BITS && cmd_q[`ARCC_CMD_REG_BIT]
                         && !cmd_q[`ARCC_CMD_RD_BIT]) begin
               case (cmd_q[1:0])
                  `ARCC_ADDR_CTRL: ctrl_q <= byte_in;
                  `ARCC_ADDR_AUX: begin
                     aux_dir_q <= byte_in[3:0];
                     aux_lvl_q <= byte_in[7:4];
                  end
                  default: ;  // Data word is read only
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial output: updates on falling edges, released outside a frame
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdy_dout      <= 1'b1;
         o_rdy_dout_oe_n <= 1'b1;
         sout_q          <= 16'h0000;
         obit_q          <= 5'h00;
      end else if (i_cs_n) begin
         o_rdy_dout_oe_n <= 1'b1;
         obit_q          <= 5'h00;
      end else if (cs_n_q) begin
         o_rdy_dout_oe_n <= 1'b0;
         o_rdy_dout      <= ~f_vld;
      end else if (rise && bit_q == `ARCC_CMD_BITS && byte_in[`ARCC_CMD_REG_BIT]
                   && byte_in[`ARCC_CMD_RD_BIT]) begin
         obit_q <= `ARCC_OUT_BITS;
         case (byte_in[1:0])
            `ARCC_ADDR_CTRL: sout_q <= {8'h00, ctrl_q};
            `ARCC_ADDR_AUX:  sout_q <= {8'h00, i_aux_pin, aux_dir_q};
            `ARCC_ADDR_DATA: sout_q <= f_vld ? f_data : 16'h0000;
            default:         sout_q <= 16'h0000;
         endcase
      end else if (fall) begin
         if (obit_q != 5'h00) begin
            o_rdy_dout <= sout_q[15];
            sout_q     <= {sout_q[14:0], 1'b0};
            obit_q     <= obit_q - 1'b1;
         end else begin
            o_rdy_dout <= ~f_vld;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timing: internal oscillator or external pin, then divide by ten
   assign nco_sum  = {1'b0, nco_q} + {1'b0, (ctrl_q[`ARCC_CTL_MAINS] ? L_INC_SLOW
                                                                    : L_INC_FAST)};
   assign sys_tick = ctrl_q[`ARCC_CTL_EXT] ? (i_ext_clk & ~external_timing_source_sel_q)
                                           : nco_sum[`ARCC_NCO_BITS];
   assign fs_tick  = sys_tick && (div_q == `ARCC_FS_DIV - 1'b1);
   assign len      = conv_len(ctrl_q[`ARCC_CTL_SINGLE], o_rate_code) >> P_LEN_SHIFT;

   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         nco_q        <= {`ARCC_NCO_BITS{1'b0}};
         external_timing_source_sel_q     <= 1'b0;
         div_q        <= 4'h0;
         o_mod_sample <= 1'b0;
      end else begin
         nco_q        <= nco_sum[`ARCC_NCO_BITS-1:0];
         external_timing_source_sel_q     <= i_ext_clk;
         o_mod_sample <= fs_tick;
         if (sys_tick) begin
            div_q <= fs_tick ? 4'h0 : div_q + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer; a full FIFO holds it in S_HOLD
   assign f_push = (st_q == S_HOLD) &&
                   (ctrl_q[`ARCC_CTL_SINGLE] || settle_q == `ARCC_SETTLE);

   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_q       <= S_IDLE;
         cnt_q      <= 18'h00000;
         settle_q   <= 2'h0;
         o_conv_end <= 1'b0;
      end else begin
         o_conv_end <= 1'b0;
         if (start_q) begin
            // A new command restarts settling
            st_q     <= S_RUN;
            cnt_q    <= 18'h00000;
            settle_q <= 2'h0;
         end else begin
            case (st_q)
               S_IDLE: ;
               S_RUN: begin
                  if (fs_tick) begin
                     if (cnt_q >= len - 1'b1) begin
                        st_q       <= S_HOLD;
                        o_conv_end <= 1'b1;
                     end else begin
                        cnt_q <= cnt_q + 1'b1;
                     end
                  end
               end
               S_HOLD: begin
                  if (!f_push) begin
                     // Dropped settling result, keep converting
                     settle_q <= settle_q + 1'b1;
                     st_q     <= S_RUN;
                     cnt_q    <= 18'h00000;
                  end else if (f_rdy) begin
                     st_q  <= ctrl_q[`ARCC_CTL_SINGLE] ? S_IDLE : S_RUN;
                     cnt_q <= 18'h00000;
                  end
               end
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration outputs, all from flops
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_input_buffer_enable        <= 1'b0;
         o_unipolar                   <= 1'b0;
         o_external_timing_source_sel <= 1'b0;
         o_mains_frequency_select     <= 1'b0;
         o_aux_pin                    <= 4'h0;
         o_aux_pin_oe_n               <= 4'hF;
      end else begin
         o_input_buffer_enable        <= ctrl_q[`ARCC_CTL_BUF];
         o_unipolar                   <= ctrl_q[`ARCC_CTL_UNI];
         o_external_timing_source_sel <= ctrl_q[`ARCC_CTL_EXT];
         o_mains_frequency_select     <= ctrl_q[`ARCC_CTL_MAINS];
         o_aux_pin                    <= aux_lvl_q;
         o_aux_pin_oe_n               <= ~aux_dir_q;
      end
   end

   arcc_fifo #(
      .P_WIDTH (16),
      .P_DEPTH (P_FIFO_DEPTH),
      .P_AW    (3)
   ) u_fifo (
      .i_clock     (i_clock),
      .i_arst_n    (i_arst_n),
      .i_in_valid  (f_push),
      .i_in_data   (i_sample_data),
      .o_in_ready  (f_rdy),
      .o_out_valid (f_vld),
      .o_out_data  (f_data),
      .i_out_ready (f_pop)
   );
endmodule // arcc_top

// File: include/arcc_consts.vh
// Constants for the converter rate and clock control block.
// Assumes one 40 MHz system clock; serial pins are already synchronous to it.
`ifndef ARCC_CONSTS_VH
`define ARCC_CONSTS_VH

// Clock rates in Hz
`define ARCC_CLK_HZ        40000000
`define ARCC_OSC_FAST_HZ   2457600
`define ARCC_OSC_SLOW_HZ   2048000
`define ARCC_NCO_BITS      24
// Timing source ticks per modulator sample
`define ARCC_FS_DIV        4'hA
// Continuous results dropped after a start
`define ARCC_SETTLE        2'h3

// Command byte layout
`define ARCC_CMD_REG_BIT   7
`define ARCC_CMD_RD_BIT    6
`define ARCC_ADDR_CTRL     2'h0
`define ARCC_ADDR_AUX      2'h1
`define ARCC_ADDR_DATA     2'h2
`define ARCC_CMD_BITS      5'h07
`define ARCC_WR_BITS       5'h0F
`define ARCC_OUT_BITS      5'h10

// First control register fields and reset value
`define ARCC_CTL_EXT       0
`define ARCC_CTL_MAINS     1
`define ARCC_CTL_BUF       2
`define ARCC_CTL_UNI       3
`define ARCC_CTL_SINGLE    4
`define ARCC_CTL_RESET     8'h00

// Modulator samples per result (245760 Hz over rate)
`define ARCC_LEN_CONT_4    18'h01000
`define ARCC_LEN_CONT_5    18'h00800
`define ARCC_LEN_CONT_6    18'h00400
`define ARCC_LEN_CONT_7    18'h00200
`define ARCC_LEN_SNG_0     18'h3C000
`define ARCC_LEN_SNG_1     18'h18000
`define ARCC_LEN_SNG_2     18'h0C000
`define ARCC_LEN_SNG_3     18'h06000
`define ARCC_LEN_SNG_4     18'h04000
`define ARCC_LEN_SNG_5     18'h02000
`define ARCC_LEN_SNG_6     18'h01000
`define ARCC_LEN_SNG_7     18'h00800

`endif

// File: dv/arcc_top_sva.sv
// Checker for the converter control top: serial line timing and pulses.
// Assumes it is bound to arcc_top and sees only that module's ports.
`timescale 1ns/10ps
module arcc_top_sva (
   // Clock and reset
   input wire       i_clock,
   input wire       i_arst_n,
   // Serial port
   input wire       i_cs_n,
   input wire       i_sclk,
   input wire       o_rdy_dout,
   input wire       o_rdy_dout_oe_n,
   // Timing and settings
   input wire       o_mod_sample,
   input wire       o_conv_end,
   input wire       o_input_buffer_enable,
   input wire       o_unipolar,
   input wire [2:0] o_rate_code,
   input wire [3:0] o_aux_pin,
   input wire [3:0] o_aux_pin_oe_n
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   ////////////////////////////////////////
   // Line drive follows chip select
   oe_release_a : assert property (i_cs_n && $past(i_cs_n) |-> o_rdy_dout_oe_n)
      else $error("line still driven while deselected");
   drive_start_a : assert property ($fell(i_cs_n) |-> ##[1:2] !o_rdy_dout_oe_n)
      else $error("line not driven after select");
   // Inside a frame the line only moves after a falling serial clock
   dout_edge_a : assert property ($changed(o_rdy_dout) && !i_cs_n && !$past(i_cs_n)
      && !$past(i_cs_n, 2) && !$past(i_cs_n, 3) && !$past(i_cs_n, 4)
      |-> ($past(i_sclk, 2) && !$past(i_sclk, 1)) || ($past(i_sclk, 3) && !$past(i_sclk, 2))
      || ($past(i_sclk, 4) && !$past(i_sclk, 3)))
      else $error("line moved without a falling serial clock");
   ////////////////////////////////////////
   // Settings hold while deselected; serial clock noise must not reach them
   cfg_hold_a : assert property (i_cs_n && $past(i_cs_n) && $past(i_cs_n, 2) && $past(i_cs_n, 3)
      |-> $stable(o_input_buffer_enable) && $stable(o_unipolar))
      else $error("settings changed while deselected");
   aux_hold_a : assert property (i_cs_n && $past(i_cs_n) && $past(i_cs_n, 2) && $past(i_cs_n, 3)
      |-> $stable(o_aux_pin) && $stable(o_aux_pin_oe_n))
      else $error("aux pins changed while deselected");
   rate_hold_a : assert property (i_cs_n && $past(i_cs_n) && $past(i_cs_n, 2) && $past(i_cs_n, 3)
      |-> $stable(o_rate_code))
      else $error("rate code changed while deselected");
   // A modulator sample takes ten system ticks, so pulses are spaced out
   mod_space_a : assert property (o_mod_sample |=> !o_mod_sample [*8])
      else $error("modulator pulses too close");
   end_space_a : assert property (o_conv_end |=> !o_conv_end [*8])
      else $error("conversion end pulses too close");
   // Main scenarios reached
   cover property (o_conv_end);
   cover property ($fell(o_rdy_dout_oe_n));
   cover property (o_mod_sample && !o_rdy_dout_oe_n);
endmodule // arcc_top_sva
bind arcc_top arcc_top_sva u_sva (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_cs_n(i_cs_n),
   .i_sclk(i_sclk), .o_rdy_dout(o_rdy_dout), .o_rdy_dout_oe_n(o_rdy_dout_oe_n),
   .o_mod_sample(o_mod_sample), .o_conv_end(o_conv_end),
   .o_input_buffer_enable(o_input_buffer_enable), .o_unipolar(o_unipolar),
   .o_rate_code(o_rate_code), .o_aux_pin(o_aux_pin), .o_aux_pin_oe_n(o_aux_pin_oe_n));

// File: dv/arcc_host_model.sv
// Serial host model: frames each access with chip select, clock idles low.
// Assumes the bench clock is the device clock; serial half period is 4 clocks.
`timescale 1ns/10ps
module arcc_host_model (
   // Clock
   input  wire i_clock,
   // Serial pins; idle is deselected with the serial clock parked low
   output reg  o_cs_n = 1'b1,
   output reg  o_sclk = 1'b0,
   output reg  o_din  = 1'b0,
   input  wire i_rdy_dout
);
   ////////////////////////////////////////
   // Serial clock and data toggled while deselected; the device must ignore them
   task noise(input [15:0] tx);
      integer i;
      begin
         for (i = 15; i >= 0; i = i - 1) begin
            @(posedge i_clock) o_din <= tx[i];
            repeat (4) @(posedge i_clock);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clock);
            o_sclk <= 1'b0;
         end
      end
   endtask
   ////////////////////////////////////////
   // One frame, MSB first; line is sampled at each rise, ready after select
   task xfer(input [23:0] tx, input integer nb, output [23:0] rx, output rdy);
      integer i;
      begin
         rx = 24'h000000;
         @(posedge i_clock) o_cs_n <= 1'b0;
         repeat (3) @(posedge i_clock);
         rdy = i_rdy_dout;
         for (i = nb - 1; i >= 0; i = i - 1) begin
            o_din <= tx[i];
            repeat (4) @(posedge i_clock);
            o_sclk <= 1'b1;
            rx = {rx[22:0], i_rdy_dout};
            repeat (4) @(posedge i_clock);
            o_sclk <= 1'b0;
         end
         repeat (4) @(posedge i_clock);
         o_cs_n <= 1'b1;
         // Data input flips after deselect so stale bits never pass
         o_din <= ~o_din;
         repeat (2) @(posedge i_clock);
      end
   endtask
endmodule // arcc_host_model

// File: dv/tb.sv
// Self-checking bench for the converter control top.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`include "arcc_consts.vh"
module tb;
   localparam SH = 8; // Shortened conversions
   localparam TPS = 16276; // Clocks per modulator sample, times 100
   reg         clk;
   reg         arst_n;
   reg         ext_clk = 1'b0;
   reg  [1:0]  ecnt = 2'h0;
   reg  [15:0] sample;
   reg  [3:0]  aux_in;
   wire        cs_n, sclk, din, rdy, rdy_oe_n, line, mod_s, c_end;
   wire        buf_en, uni, ext_sel, mains;
   wire [2:0]  rate;
   wire [3:0]  aux_out, aux_oe_n;
   integer     failures, n_tests, n, i, e, words;
   reg  [23:0] rx;
   reg         rdy_seen;
   reg  [2:0]  c;
   reg  [17:0] len;
   arcc_top #(.P_LEN_SHIFT(SH), .P_FIFO_DEPTH(8)) dut_u (.i_clock(clk), .i_arst_n(arst_n),
      .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_rdy_dout(rdy), .o_rdy_dout_oe_n(rdy_oe_n),
      .i_ext_clk(ext_clk), .i_sample_data(sample), .o_mod_sample(mod_s), .o_conv_end(c_end),
      .o_input_buffer_enable(buf_en), .o_unipolar(uni), .o_external_timing_source_sel(ext_sel),
      .o_mains_frequency_select(mains), .o_rate_code(rate), .i_aux_pin(aux_in),
      .o_aux_pin(aux_out), .o_aux_pin_oe_n(aux_oe_n));
   // Released line reads as the inverse of the last level
   assign line = rdy_oe_n ? ~rdy : rdy;
   arcc_host_model host_u (.i_clock(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din),
      .i_rdy_dout(line));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // External timing pin, period of eight clocks
   always @(posedge clk) begin
      ecnt <= ecnt + 2'h1;
      if (ecnt == 2'h3) ext_clk <= ~ext_clk;
   end
   ////////////////////////////////////////
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("Comparisons %0d, mismatches %0d", n_tests, failures);
         if (failures == 0 && n_tests > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // Register write, register read, conversion command, ready probe
   task wr(input [1:0] a, input [7:0] v);
      host_u.xfer({8'h00, 6'h20, a, v}, 16, rx, rdy_seen);
   endtask
   task rd(input [1:0] a);
      host_u.xfer({6'h30, a, 16'h0000}, 24, rx, rdy_seen);
   endtask
   task cmd(input [2:0] code);
      host_u.xfer({21'h000000, code}, 8, rx, rdy_seen);
   endtask
   task probe;
      host_u.xfer(24'h000000, 0, rx, rdy_seen);
   endtask
   // Clocks until a pulse (1 modulator, 0 conversion end); a hang ends the run
   task wait_pulse(input integer sel);
      begin
         n = 0;
         @(posedge clk);
         while ((sel ? mod_s : c_end) !== 1'b1) begin
            n = n + 1;
            if (n > 30000) begin
               failures = failures + 1;
               test_done;
            end
            @(posedge clk);
         end
      end
   endtask
   task gap(input integer sel, input integer exp);
      begin
         wait_pulse(sel);
         wait_pulse(sel);
         chk(n + 1 >= exp - 2 && n + 1 <= exp + 2, 1'b1);
      end
   endtask
   task count_ends(input integer cyc);
      begin
         e = 0;
         repeat (cyc) @(posedge clk) if (c_end === 1'b1) e = e + 1;
      end
   endtask
   ////////////////////////////////////////
   task t_setup;
      begin
         chk({rdy, rdy_oe_n, buf_en, uni, ext_sel, mains}, 16'h0030);
         chk(aux_oe_n, 4'hF);
         wr(2'h0, 8'h0C);
         chk({ext_sel, mains, buf_en, uni}, 4'h3);
         wr(2'h0, 8'h03);
         chk({ext_sel, mains, buf_en, uni}, 4'hC);
         @(posedge clk) aux_in <= 4'h6;
         wr(2'h1, 8'hA5);
         chk({aux_out, aux_oe_n}, 8'hAA);
         rd(2'h1);
         chk(rx[15:0], 16'h0065);
         // A full write frame clocked in while deselected must change nothing
         host_u.noise(16'h80FF);
         chk({ext_sel, mains, buf_en, uni}, 4'hC);
         $display("test setup done");
      end
   endtask
   task t_clock;
      begin
         wr(2'h0, 8'h00);
         cmd(3'h0);
         gap(1, TPS / 100);
         wr(2'h0, 8'h02);
         gap(1, 195);
         wr(2'h0, 8'h01);
         gap(1, 80);
         $display("test clock done");
      end
   endtask
   task t_cont;
      begin
         wr(2'h0, 8'h00);
         for (i = 3; i < 8; i = i + 1) begin
            c = (i == 3) ? 3'h0 : i[2:0];
            len = (c == 3'h7) ? `ARCC_LEN_CONT_7 : (c == 3'h6) ? `ARCC_LEN_CONT_6 :
                  (c == 3'h5) ? `ARCC_LEN_CONT_5 : `ARCC_LEN_CONT_4;
            cmd(c);
            chk(rate, c);
            gap(0, (len >> SH) * TPS / 100);
         end
         $display("test continuous done");
      end
   endtask
   task t_fifo;
      begin
         cmd(3'h7);
         repeat (3) wait_pulse(0);
         probe;
         chk(rdy_seen, 1'b1);
         wait_pulse(0);
         probe;
         chk(rdy_seen, 1'b0);
         repeat (5000) @(posedge clk);
         count_ends(1000);
         chk(e, 0);
         wr(2'h0, 8'h10);
         cmd(3'h0);
         words = 0;
         rd(2'h2);
         while (rx[15:0] === 16'h5A3C && words < 10) begin
            words = words + 1;
            rd(2'h2);
         end
         chk(rx[15:0], 16'h0000);
         chk(words, 8);
         probe;
         chk(rdy_seen, 1'b1);
         $display("test fifo done");
      end
   endtask
   task t_single;
      begin
         for (i = 4; i < 8; i = i + 1) begin
            c = i[2:0];
            len = (c == 3'h7) ? `ARCC_LEN_SNG_7 : (c == 3'h6) ? `ARCC_LEN_SNG_6 :
                  (c == 3'h5) ? `ARCC_LEN_SNG_5 : `ARCC_LEN_SNG_4;
            cmd(c);
            wait_pulse(0);
            chk(n + 175 >= (len >> SH) * TPS / 100 && n <= (len >> SH) * TPS / 100 + 165,
                1'b1);
            probe;
            chk(rdy_seen, 1'b0);
            rd(2'h2);
            chk(rx[15:0], 16'h5A3C);
            count_ends((len >> SH) * 170);
            chk(e, 0);
         end
         $display("test single done");
      end
   endtask
   ////////////////////////////////////////
   initial begin
      failures = 0;
      n_tests = 0;
      arst_n = 1'b0;
      sample = 16'h5A3C;
      aux_in = 4'h0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_setup;
      t_clock;
      t_cont;
      t_fifo;
      t_single;
      test_done;
   end
endmodule // tb
